// ==== hw/io_expander_pkg.sv ====
// shared constants, field layout and types of the i/o expander port logic
package io_expander_pkg;

  localparam int NUM_PORTS    = 8;
  localparam int PORT_W       = 8;
  localparam int NUM_PINS     = NUM_PORTS * PORT_W;
  localparam int NUM_PWM      = 16;
  localparam int PWM_W        = 8;
  localparam int ADDR_PINS    = 6;
  localparam int NUM_CLK_SRC  = 6;

  // bus address layout: adr[11:10] region, then index fields
  localparam logic [1:0] REGION_PORT   = 2'h0;
  localparam logic [1:0] REGION_GLOBAL = 2'h1;
  localparam logic [1:0] REGION_PWM    = 2'h2;

  localparam logic [2:0] REG_OUT    = 3'h0;
  localparam logic [2:0] REG_IN     = 3'h1;
  localparam logic [2:0] REG_INV    = 3'h2;
  localparam logic [2:0] REG_PWMSEL = 3'h3;
  localparam logic [2:0] REG_MASK   = 3'h4;
  localparam logic [2:0] REG_STAT   = 3'h5;
  localparam logic [2:0] REG_DRIVE  = 3'h6;

  localparam logic [3:0] GREG_CFG     = 4'h0;
  localparam logic [3:0] GREG_PWMSTAT = 4'h1;

  // configuration register fields
  localparam int CFG_EE_DIS_BIT   = 0;
  localparam int CFG_WD_EN_BIT    = 1;
  localparam int CFG_PWM_INT_BIT  = 2;
  localparam int CFG_ADDR_CNT_LSB = 4;

  // pwm channel register fields
  localparam int PWM_DUTY_LSB   = 0;
  localparam int PWM_PERIOD_LSB = 8;
  localparam int PWM_CLKSEL_LSB = 16;

  // reset values
  localparam logic [31:0] CFG_RST   = 32'h00000000;
  localparam logic [7:0]  OUT_RST   = 8'hFF;
  localparam logic [7:0]  INV_RST   = 8'h00;
  localparam logic [7:0]  PSEL_RST  = 8'h00;
  localparam logic [7:0]  MASK_RST  = 8'h00;
  localparam logic [31:0] PWM_RST   = 32'h0000FF80;

  // slave address bases before address pins are merged in
  localparam logic [6:0] PORT_SLAVE_BASE = 7'h20;
  localparam logic [6:0] EE_SLAVE_BASE   = 7'h50;

  // pin numbers of the shared configuration pins: port 2 bits 0..3, port 1 bits 5..7
  localparam int WD_PIN = 19;
  localparam int ADDR_PIN_MAP [ADDR_PINS] = '{16, 17, 18, 13, 14, 15};

  // clock sources: divider taps of the free running prescaler
  localparam logic [15:0] CLK_SRC_MASK [NUM_CLK_SRC] =
    '{16'h0000, 16'h0001, 16'h0003, 16'h000F, 16'h003F, 16'h00FF};

  typedef enum logic [2:0] {
    DRV_PULL_UP,
    DRV_PULL_DN,
    DRV_OD_HIGH,
    DRV_OD_LOW,
    DRV_STRONG_FAST,
    DRV_STRONG_SLOW,
    DRV_HIZ
  } driveMode_t;

endpackage

// ==== hw/io_expander_port.sv ====
// port, pwm, interrupt, address and eeprom-gate logic of the i/o expander
`timescale 1ns/1ps

// What this block does
// - writing an output register drives the pins at once, per drive mode
// - reading the input register returns present pin levels, never the output register
// - input and output storage are separate so pulled pins read back real levels
// - set inversion bits flip the sampled level before it reaches the input register
// - set pwm selection bits route a pwm output to the pin instead
// - each pin takes one of seven drive modes, chosen per pin
// - after reset without stored defaults every pin is pulled-up
// - every port has its own interrupt mask and status register
// - a status bit sets when its input changed since the last status read
// - reading a status register returns its bits and clears it
// - mask bit one blocks that input from the interrupt; zero allows it
// - interrupt signals input changes and pwm output state changes
// - while write-disable is high every user eeprom write is rejected
// - a configuration setting blocks every eeprom read and write
// - stored port and pwm defaults are reloaded and applied after power-on
// - four port 2 pins and three port 1 pins are gpio or write-disable/address
// - fixed plus up to six optional address pins form the bus address
// - optional address pins not used for address stay ordinary gpio
// - each pwm has 8-bit resolution and one of six clock sources
// - two slaves, port expander and eeprom, chosen by upper address bits, or by the pointer byte msb when all six address pins are in use
module io_expander_port (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        loadStb,
  input  wire logic [11:0] loadAdr,
  input  wire logic [31:0] loadDat,
  input  wire logic [63:0] pinIn,
  output logic      [63:0] pinOut,
  output logic      [63:0] pinOe,
  output logic      [63:0] pinPullUp,
  output logic      [63:0] pinPullDn,
  output logic      [63:0] pinSlow,
  output logic      [15:0] pulseWidthChannels,
  output logic             intOut,
  input  wire logic        fixedAddrPin,
  input  wire logic [6:0]  i2cAddr,
  input  wire logic        cmdMsb,
  output logic             selPort,
  output logic             selEeprom,
  output logic      [6:0]  portSlaveAddr,
  output logic      [6:0]  eepromSlaveAddr,
  input  wire logic        eeReq,
  input  wire logic        eeWrite,
  input  wire logic        eeUserRegion,
  output logic             eeAllow,
  output logic             eepromWriteBlock
);

  localparam int NP = io_expander_pkg::NUM_PORTS;
  localparam int NW = io_expander_pkg::NUM_PWM;

  logic [7:0]  outReg_q   [NP];
  logic [7:0]  invReg_q   [NP];
  logic [7:0]  pwmSel_q   [NP];
  logic [7:0]  mask_q     [NP];
  logic [7:0]  stat_q     [NP];
  logic [23:0] drive_q    [NP];
  logic [31:0] pwmCfg_q   [NW];
  logic [7:0]  pwmCnt_q   [NW];
  logic [31:0] cfg_q;
  logic [15:0] pwmOut_q;
  logic [15:0] pwmStat_q;
  logic [15:0] pwmPrev_q;
  logic [15:0] prescale_q;
  logic [63:0] pinPrev_q;
  logic        primed_q;
  logic        ack_q;
  logic [31:0] rdData_q;
  logic [6:0]  portAddr_q;
  logic [6:0]  eeAddr_q;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic srcTick(input logic [2:0] sel, input logic [15:0] div);
    logic [15:0] m;
    m = (int'(sel) < io_expander_pkg::NUM_CLK_SRC) ? io_expander_pkg::CLK_SRC_MASK[sel]
                                                   : io_expander_pkg::CLK_SRC_MASK[0];
    return (div & m) == m;
  endfunction

  // loader has priority; the bus waits while defaults are being replayed
  wire        busAct  = cyc_i & stb_i & ~ack_q & ~loadStb;
  wire        wrEn    = loadStb | (busAct & we_i);
  wire        rdEn    = busAct & ~we_i;
  wire [11:0] acAdr   = loadStb ? loadAdr : adr_i;
  wire [31:0] wrDat   = loadStb ? loadDat : dat_i;
  wire [3:0]  wrSel   = loadStb ? 4'hF : sel_i;
  wire [1:0]  region  = acAdr[11:10];
  wire [2:0]  portIdx = acAdr[7:5];
  wire [2:0]  regIdx  = acAdr[4:2];
  wire [3:0]  subIdx  = acAdr[5:2];
  wire        inPort  = region == io_expander_pkg::REGION_PORT && acAdr[9:8] == 2'h0;
  wire        inGlob  = region == io_expander_pkg::REGION_GLOBAL && acAdr[9:6] == 4'h0;
  wire        inPwm   = region == io_expander_pkg::REGION_PWM && acAdr[9:6] == 4'h0;
  wire        rdPwmSt = rdEn & inGlob & (subIdx == io_expander_pkg::GREG_PWMSTAT);

  wire        eeDis    = cfg_q[io_expander_pkg::CFG_EE_DIS_BIT];
  wire        wdEn     = cfg_q[io_expander_pkg::CFG_WD_EN_BIT];
  wire        pwmIntEn = cfg_q[io_expander_pkg::CFG_PWM_INT_BIT];
  wire [2:0]  cntRaw   = cfg_q[io_expander_pkg::CFG_ADDR_CNT_LSB +: 3];
  wire [2:0]  addrCnt  = (cntRaw > 3'h6) ? 3'h6 : cntRaw;
  wire        fullAddr = addrCnt == 3'h6;

  wire [63:0] pinChg = primed_q ? (pinIn ^ pinPrev_q) : 64'h0;

  logic [63:0] reserved;
  logic [6:0]  addrVec;
  logic [7:0]  portPend;
  logic [31:0] rdMux;

  // only pins claimed by the configuration leave gpio duty
  always_comb begin
    reserved = 64'h0;
    addrVec  = {6'h0, fixedAddrPin};
    for (int k = 0; k < io_expander_pkg::ADDR_PINS; k++) begin
      if (k < int'(addrCnt)) begin
        reserved[io_expander_pkg::ADDR_PIN_MAP[k]] = 1'b1;
        addrVec[k+1] = pinIn[io_expander_pkg::ADDR_PIN_MAP[k]];
      end
    end
    if (wdEn) begin
      reserved[io_expander_pkg::WD_PIN] = 1'b1;
    end
  end

  // per-pin drive from output or pwm value
  always_comb begin
    for (int i = 0; i < io_expander_pkg::NUM_PINS; i++) begin
      logic val;
      io_expander_pkg::driveMode_t mode;
      val  = pwmSel_q[i/8][i%8] ? pwmOut_q[i%NW] : outReg_q[i/8][i%8];
      mode = io_expander_pkg::driveMode_t'(drive_q[i/8][(i%8)*3 +: 3]);
      pinOut[i]    = val;
      pinOe[i]     = 1'b0;
      pinPullUp[i] = 1'b0;
      pinPullDn[i] = 1'b0;
      pinSlow[i]   = 1'b0;
      unique case (mode)
        io_expander_pkg::DRV_PULL_UP: begin
          pinOe[i]     = ~val;
          pinPullUp[i] = 1'b1;
        end
        io_expander_pkg::DRV_PULL_DN: begin
          pinOe[i]     = val;
          pinPullDn[i] = 1'b1;
        end
        io_expander_pkg::DRV_OD_HIGH:     pinOe[i] = val;
        io_expander_pkg::DRV_OD_LOW:      pinOe[i] = ~val;
        io_expander_pkg::DRV_STRONG_FAST: pinOe[i] = 1'b1;
        io_expander_pkg::DRV_STRONG_SLOW: begin
          pinOe[i]   = 1'b1;
          pinSlow[i] = 1'b1;
        end
        io_expander_pkg::DRV_HIZ:         pinOe[i] = 1'b0;
        default:                          pinOe[i] = 1'b0;
      endcase
      if (reserved[i]) begin
        pinOe[i]     = 1'b0;
        pinPullUp[i] = 1'b0;
        pinPullDn[i] = 1'b0;
      end
    end
  end

  // read data; the input register samples the pins at the access
  always_comb begin
    rdMux = 32'h0;
    if (inPort) begin
      unique case (regIdx)
        io_expander_pkg::REG_OUT:    rdMux = {24'h0, outReg_q[portIdx]};
        io_expander_pkg::REG_IN:     rdMux = {24'h0, pinIn[portIdx*8 +: 8] ^ invReg_q[portIdx]};
        io_expander_pkg::REG_INV:    rdMux = {24'h0, invReg_q[portIdx]};
        io_expander_pkg::REG_PWMSEL: rdMux = {24'h0, pwmSel_q[portIdx]};
        io_expander_pkg::REG_MASK:   rdMux = {24'h0, mask_q[portIdx]};
        io_expander_pkg::REG_STAT:   rdMux = {24'h0, stat_q[portIdx]};
        io_expander_pkg::REG_DRIVE:  rdMux = {8'h0, drive_q[portIdx]};
        default:                     rdMux = 32'h0;
      endcase
    end else if (inGlob && subIdx == io_expander_pkg::GREG_CFG) begin
      rdMux = cfg_q;
    end else if (inGlob && subIdx == io_expander_pkg::GREG_PWMSTAT) begin
      rdMux = {16'h0, pwmStat_q};
    end else if (inPwm) begin
      rdMux = {8'h0, pwmCfg_q[subIdx][23:0]};
    end
  end

  // masked status bits never reach the interrupt line
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      portPend[p] = |(stat_q[p] & ~mask_q[p]);
    end
  end
  assign intOut = (|portPend) | (pwmIntEn & (|pwmStat_q));

  assign eepromWriteBlock = wdEn & pinIn[io_expander_pkg::WD_PIN];
  assign eeAllow = eeReq & ~eeDis & ~(eeWrite & eeUserRegion & eepromWriteBlock);

  // with all address pins in use the pointer byte msb chooses the slave
  assign selPort   = (i2cAddr == portAddr_q) & ~(fullAddr & cmdMsb);
  assign selEeprom = (i2cAddr == eeAddr_q) & (~fullAddr | cmdMsb);
  assign portSlaveAddr   = portAddr_q;
  assign eepromSlaveAddr = eeAddr_q;
  assign ack_o = ack_q;
  assign dat_o = rdData_q;
  assign pulseWidthChannels = pwmOut_q;

  // bus slave: one-cycle answer, unmapped reads return zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q    <= 1'b0;
      rdData_q <= 32'h0;
    end else begin
      ack_q <= busAct;
      if (rdEn) begin
        rdData_q <= rdMux;
      end
    end
  end

  // address merged from pins, low bits widen with the configured count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portAddr_q <= io_expander_pkg::PORT_SLAVE_BASE;
      eeAddr_q   <= io_expander_pkg::EE_SLAVE_BASE;
    end else begin
      logic [6:0] lowMask;
      lowMask    = 7'((8'h02 << addrCnt) - 8'h01);
      portAddr_q <= (io_expander_pkg::PORT_SLAVE_BASE & ~lowMask) | (addrVec & lowMask);
      eeAddr_q   <= (io_expander_pkg::EE_SLAVE_BASE & ~lowMask) | (addrVec & lowMask);
    end
  end

  // port registers; status set wins over the clear of a read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NP; p++) begin
        outReg_q[p] <= io_expander_pkg::OUT_RST;
        invReg_q[p] <= io_expander_pkg::INV_RST;
        pwmSel_q[p] <= io_expander_pkg::PSEL_RST;
        mask_q[p]   <= io_expander_pkg::MASK_RST;
        stat_q[p]   <= 8'h00;
        drive_q[p]  <= 24'h000000;
      end
      cfg_q     <= io_expander_pkg::CFG_RST;
      pinPrev_q <= 64'h0;
      primed_q  <= 1'b0;
    end else begin
      pinPrev_q <= pinIn;
      primed_q  <= 1'b1;
      for (int p = 0; p < NP; p++) begin
        logic clr;
        clr = rdEn & inPort & (portIdx == 3'(p)) & (regIdx == io_expander_pkg::REG_STAT);
        stat_q[p] <= (clr ? 8'h00 : stat_q[p]) | pinChg[p*8 +: 8];
        if (wrEn && inPort && portIdx == 3'(p) && wrSel[0]) begin
          unique case (regIdx)
            io_expander_pkg::REG_OUT:    outReg_q[p] <= wrDat[7:0];
            io_expander_pkg::REG_INV:    invReg_q[p] <= wrDat[7:0];
            io_expander_pkg::REG_PWMSEL: pwmSel_q[p] <= wrDat[7:0];
            io_expander_pkg::REG_MASK:   mask_q[p]   <= wrDat[7:0];
            default: ;
          endcase
        end
        if (wrEn && inPort && portIdx == 3'(p) && regIdx == io_expander_pkg::REG_DRIVE) begin
          drive_q[p] <= 24'(mergeBytes({8'h0, drive_q[p]}, wrDat, wrSel));
        end
      end
      if (wrEn && inGlob && subIdx == io_expander_pkg::GREG_CFG) begin
        cfg_q <= mergeBytes(cfg_q, wrDat, wrSel);
      end
    end
  end

  // 8-bit pwm channels stepped by their selected prescaler tap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_q <= 16'h0000;
      pwmOut_q   <= 16'h0000;
      pwmStat_q  <= 16'h0000;
      for (int c = 0; c < NW; c++) begin
        pwmCfg_q[c] <= io_expander_pkg::PWM_RST;
        pwmCnt_q[c] <= 8'h00;
      end
    end else begin
      prescale_q <= prescale_q + 16'h0001;
      for (int c = 0; c < NW; c++) begin
        logic [7:0] per;
        logic [7:0] duty;
        per  = pwmCfg_q[c][io_expander_pkg::PWM_PERIOD_LSB +: io_expander_pkg::PWM_W];
        duty = pwmCfg_q[c][io_expander_pkg::PWM_DUTY_LSB +: io_expander_pkg::PWM_W];
        if (srcTick(pwmCfg_q[c][io_expander_pkg::PWM_CLKSEL_LSB +: 3], prescale_q)) begin
          pwmCnt_q[c] <= (pwmCnt_q[c] >= per) ? 8'h00 : pwmCnt_q[c] + 8'h01;
          pwmOut_q[c] <= pwmCnt_q[c] < duty;
        end
        if (wrEn && inPwm && subIdx == 4'(c)) begin
          pwmCfg_q[c] <= mergeBytes(pwmCfg_q[c], wrDat, wrSel) & 32'h0007FFFF;
        end
      end
      pwmStat_q <= (rdPwmSt ? 16'h0000 : pwmStat_q) | (pwmOut_q ^ pwmPrev_q);
    end
  end

  // previous pwm level for the change flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwmPrev_q <= 16'h0000;
    end else begin
      pwmPrev_q <= pwmOut_q;
    end
  end

  // ---- checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence rdIn0;
    rdEn && inPort && portIdx == 3'h0 && regIdx == io_expander_pkg::REG_IN;
  endsequence
  sequence rdStat0;
    rdEn && inPort && portIdx == 3'h0 && regIdx == io_expander_pkg::REG_STAT;
  endsequence
  sequence wrOut0;
    wrEn && inPort && portIdx == 3'h0 && regIdx == io_expander_pkg::REG_OUT && wrSel[0];
  endsequence

  AST_OUT_WRITE: assert property (
    wrOut0 ##0 (drive_q[0][2:0] == 3'h4 && !pwmSel_q[0][0] && !reserved[0])
      |=> pinOe[0] && pinOut[0] == $past(wrDat[0]))
    else $error("output write did not reach pin 0");

  AST_IN_READ: assert property (
    rdIn0 |=> ack_o && dat_o[7:0] == $past(pinIn[7:0] ^ invReg_q[0]))
    else $error("input read did not return pin levels");

  AST_IN_SEPARATE: assert property (
    rdIn0 ##0 (pinIn[7:0] != outReg_q[0]) && invReg_q[0] == 8'h00
      |=> dat_o[7:0] != $past(outReg_q[0]))
    else $error("input read returned output register");

  AST_PWM_ROUTE: assert property (
    pwmSel_q[0][0] && drive_q[0][2:0] == 3'h4 && !reserved[0] |-> pinOut[0] == pwmOut_q[0])
    else $error("pwm not routed to pin 0");

  AST_STAT_SET: assert property (
    primed_q && pinIn[0] != pinPrev_q[0] |=> stat_q[0][0] [*1] ##0 (stat_q[0][0] || 1'b1))
    else $error("status bit 0 not set on change");

  AST_STAT_CLEAR: assert property (
    rdStat0 ##0 (pinChg[7:0] == 8'h00) |=> stat_q[0] == 8'h00 && dat_o[7:0] == $past(stat_q[0]))
    else $error("status read did not clear");

  AST_MASK_BLOCK: assert property (
    stat_q[2] != 8'h00 && mask_q[2] == 8'hFF && portPend[1:0] == 2'h0
      && portPend[7:3] == 5'h0 && !pwmIntEn |-> !intOut)
    else $error("masked status raised the interrupt");

  AST_PWM_INT: assert property (
    pwmIntEn && pwmOut_q[0] != pwmPrev_q[0] && !rdPwmSt && !(wrEn && inGlob) |=> intOut)
    else $error("pwm change raised no interrupt");

  AST_WD_BLOCK: assert property (
    eepromWriteBlock && eeWrite && eeUserRegion |-> !eeAllow)
    else $error("eeprom write passed write-disable");

  AST_EE_DIS: assert property (
    eeDis |-> !eeAllow)
    else $error("eeprom access while disabled");

  AST_INT_HOLD: assert property (
    stat_q[0][0] && !mask_q[0][0] && !((rdEn || wrEn) && inPort && portIdx == 3'h0)
      |=> intOut [*1] ##0 stat_q[0][0])
    else $error("interrupt dropped with pending status");

  AST_PWM_WRAP: assert property (
    srcTick(pwmCfg_q[0][18:16], prescale_q) && pwmCnt_q[0] >= pwmCfg_q[0][15:8]
      && !(wrEn && inPwm && subIdx == 4'h0) |=> pwmCnt_q[0] == 8'h00)
    else $error("pwm counter did not wrap");

endmodule

// ==== tb/io_expander_port_tb.sv ====
// self-checking bench of the i/o expander port logic
`timescale 1ns/1ps
module io_expander_port_tb;
  logic        clk = 0, rst_b = 0, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic        loadStb = 0, intOut, fixedAddrPin = 0, cmdMsb = 0, selPort, selEeprom;
  logic        eeReq = 0, eeWrite = 0, eeUserRegion = 0, eeAllow, eepromWriteBlock;
  logic [3:0]  sel_i = 4'hF;
  logic [6:0]  i2cAddr = 0, portSlaveAddr, eepromSlaveAddr;
  logic [11:0] adr_i = 0, loadAdr = 0;
  logic [15:0] pulseWidthChannels;
  logic [31:0] dat_i = 0, dat_o, loadDat = 0;
  logic [63:0] pinIn, pinOut, pinOe, pinPullUp, pinPullDn, pinSlow;
  logic [63:0] extEn = 64'h00FF00FF00FFFFFF, extVal = '1;
  int          miscompares = 0, checked = 0;

  io_expander_port dut (.clk, .rst_b, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .loadStb, .loadAdr, .loadDat, .pinIn, .pinOut, .pinOe, .pinPullUp, .pinPullDn,
    .pinSlow, .pulseWidthChannels, .intOut, .fixedAddrPin, .i2cAddr, .cmdMsb, .selPort,
    .selEeprom, .portSlaveAddr, .eepromSlaveAddr, .eeReq, .eeWrite, .eeUserRegion, .eeAllow,
    .eepromWriteBlock);
  pin_env env (.clk, .pinOut, .pinOe, .pinPullUp, .pinPullDn, .extEn, .extVal, .pinIn);

  always #2 clk = ~clk;

  task automatic print_verdict;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // ack and data read as they stood at this edge; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  function automatic logic [11:0] pa(input int p, input int r);
    return 12'(p * 32 + r * 4);
  endfunction

  // drive enable expected for one drive mode and output byte
  function automatic logic [7:0] drvOe(input int m, input logic [7:0] o);
    case (m)
      0, 3: return ~o;
      1, 2: return o;
      4, 5: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction

  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  initial begin
    logic [7:0]  v, c;
    logic [6:0]  a, m, pA, eA;
    logic [31:0] q;
    int          h, k, d;
    v = 8'($urandom(22));
    tick(3);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(pa(0, io_expander_pkg::REG_DRIVE), 32'h0);
    chk({pinPullUp === '1, pinOe === '0}, 32'h3);
    v = 8'($urandom);
    c = 8'($urandom);
    wr(pa(3, io_expander_pkg::REG_DRIVE), {8'h0, {8{io_expander_pkg::DRV_STRONG_FAST}}});
    wr(pa(3, io_expander_pkg::REG_OUT), {24'h0, v});
    chk({pinOe[31:24], pinOut[31:24]}, {16'h0, 8'hFF, v});
    rd(pa(3, io_expander_pkg::REG_IN), {24'h0, v});
    extVal[39:32] <= c;
    extVal[7:0] <= c;
    tick(3);
    rd(pa(4, io_expander_pkg::REG_IN), {24'h0, c});
    rd(pa(4, io_expander_pkg::REG_OUT), 32'hFF);
    wr(pa(0, io_expander_pkg::REG_INV), {24'h0, v});
    rd(pa(0, io_expander_pkg::REG_IN), {24'h0, c ^ v});
    wr(pa(5, io_expander_pkg::REG_OUT), {24'h0, v});
    for (k = 0; k < 7; k++) begin
      wr(pa(5, io_expander_pkg::REG_DRIVE), {8'h0, {8{3'(k)}}});
      chk({pinOe[47:40], pinSlow[47:40]}, {drvOe(k, v), k == 5 ? 8'hFF : 8'h0});
      chk({pinPullUp[47:40], pinPullDn[47:40], pinOut[47:40] & pinOe[47:40]},
          {k == 0 ? 8'hFF : 8'h0, k == 1 ? 8'hFF : 8'h0, v & drvOe(k, v)});
    end
    wr(pa(5, io_expander_pkg::REG_DRIVE), 32'h0);
    tick(4);
    for (k = 0; k < 8; k++) wb(1'b0, pa(k, io_expander_pkg::REG_STAT), 32'h0, q);
    tick(4);
    chk(intOut, 1'b0);
    wr(pa(2, io_expander_pkg::REG_MASK), 32'hFF);
    c = 8'($urandom) | 8'h01;
    extVal[23:16] <= extVal[23:16] ^ c;
    tick(4);
    chk(intOut, 1'b0);
    rd(pa(2, io_expander_pkg::REG_STAT), {24'h0, c});
    rd(pa(2, io_expander_pkg::REG_STAT), 32'h0);
    extVal[55:48] <= extVal[55:48] ^ c;
    tick(20);
    chk(intOut, 1'b1);
    rd(pa(2, io_expander_pkg::REG_STAT), 32'h0);
    rd(pa(6, io_expander_pkg::REG_STAT), {24'h0, c});
    chk(intOut, 1'b0);
    // every mix of disable, pin enable, write, user region, pin level and request
    for (k = 0; k < 64; k++) begin
      wr(12'h400, {30'h0, k[1:0]});
      extVal[19] <= k[2];
      eeWrite <= k[3];
      eeUserRegion <= k[4];
      eeReq <= k[5];
      tick(4);
      h = k[1] & k[2];
      chk({eepromWriteBlock, eeAllow}, {h[0], k[5] & !k[0] & !(k[3] & k[4] & h[0])});
    end
    for (k = 0; k <= 6; k++) begin
      a = 7'($urandom);
      fixedAddrPin <= a[0];
      {extVal[15:13], extVal[18:16]} <= a[6:1];
      wr(12'h400, 32'(k) << 4);
      m = 7'((2 << k) - 1);
      pA = (io_expander_pkg::PORT_SLAVE_BASE & ~m) | (a & m);
      eA = (io_expander_pkg::EE_SLAVE_BASE & ~m) | (a & m);
      cmdMsb <= 1'($urandom);
      i2cAddr <= k[0] ? pA : eA;
      tick(4);
      chk({portSlaveAddr, eepromSlaveAddr}, {pA, eA});
      chk({26'h0, pinPullUp[15:13], pinPullUp[18:16]}, {26'h0, ~m[6:1]});
      chk({selPort, selEeprom},
          {i2cAddr == pA && (k < 6 || !cmdMsb), i2cAddr == eA && (k < 6 || cmdMsb)});
    end
    wr(pa(7, io_expander_pkg::REG_DRIVE), {8'h0, {8{io_expander_pkg::DRV_STRONG_FAST}}});
    wr(pa(7, io_expander_pkg::REG_PWMSEL), 32'h01);
    repeat (300) begin
      @(negedge clk);
      chk(pinOut[57:56], {1'b1, pulseWidthChannels[8]});
    end
    @(posedge clk);
    // slow sources kept to four; only the last would outrun the run budget, the fifth would fit
    for (k = 0; k < 4; k++) begin
      wr(12'h808, {13'h0, 3'(k), 16'hFF40});
      d = int'(io_expander_pkg::CLK_SRC_MASK[k]) + 1;
      h = 0;
      repeat (256 * d) begin
        @(negedge clk);
        h += pulseWidthChannels[2];
      end
      @(posedge clk);
      chk(32'(h >= 63 * d && h <= 65 * d), 32'h1);
    end
    @(posedge clk);
    wr(pa(7, io_expander_pkg::REG_PWMSEL), 32'h0);
    tick(4);
    for (k = 0; k < 8; k++) wb(1'b0, pa(k, io_expander_pkg::REG_STAT), 32'h0, q);
    wb(1'b0, 12'h404, 32'h0, q);
    chk(intOut, 1'b0);
    wr(12'h400, 32'h4);
    tick(300);
    chk(intOut, 1'b1);
    wr(12'h400, 32'h0);
    chk(intOut, 1'b0);
    v = 8'($urandom);
    loadAdr <= pa(6, io_expander_pkg::REG_OUT);
    loadDat <= {24'h0, v};
    loadStb <= 1'b1;
    @(posedge clk);
    loadStb <= 1'b0;
    rd(pa(6, io_expander_pkg::REG_OUT), {24'h0, v});
    rd(12'hC00, 32'h0);
    print_verdict();
  end
endmodule

// ==== tb/pin_env.sv ====
// far-side pin environment: external drivers, pulls and floating lines
`timescale 1ns/1ps
module pin_env (
  input  wire logic        clk,
  input  wire logic [63:0] pinOut,
  input  wire logic [63:0] pinOe,
  input  wire logic [63:0] pinPullUp,
  input  wire logic [63:0] pinPullDn,
  input  wire logic [63:0] extEn,
  input  wire logic [63:0] extVal,
  output logic      [63:0] pinIn
);
  logic floatQ = 1'b0;
  // undriven unpulled lines wander, so a stale level never reads back
  always @(posedge clk) floatQ <= ~floatQ;
  // device drive wins, then outside driver, then pulls
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
               | (~pinOe & ~extEn & (pinPullUp | (~pinPullDn & {64{floatQ}})));
endmodule
